// *** awsc_pkg.sv ***
// Package with register map, field positions and state codes.
package awsc_pkg;
  localparam logic [7:0] PWR_CTRL_OFF = 8'h87;
  localparam logic [7:0] AUX_IE_OFF = 8'ha6;
  localparam logic [7:0] PERIPH_PD_OFF = 8'hf1;
  localparam logic [7:0] AUX_CTRL_OFF = 8'ha7;
  localparam logic [7:0] STATUS_OFF = 8'ha8;
  localparam logic [7:0] RESULT_OFF = 8'ha9;
  localparam logic [7:0] CORE_SLEEP_MASK = 8'h02;
  localparam logic [7:0] CONV_IRQ_MASK = 8'h20;
  localparam logic [7:0] CONV_STOP_MASK = 8'h08;
  localparam int CORE_SLEEP_POS = 1;
  localparam int CONV_IRQ_POS = 5;
  localparam int CONV_STOP_POS = 3;
  localparam int GLOBAL_EN_POS = 0;
  localparam int SYNC_AUTO_POS = 1;
  localparam logic [7:0] PWR_CTRL_RST = 8'h00;
  localparam logic [7:0] AUX_IE_RST = 8'h00;
  localparam logic [7:0] PERIPH_PD_RST = 8'h00;
  localparam logic [7:0] AUX_CTRL_RST = 8'h00;
  typedef enum logic [1:0] {
    AWSC_IDLE = 2'b00,
    AWSC_ARMED = 2'b01,
    AWSC_STOPPED = 2'b10
  } awsc_sync_e;
endpackage

// *** awsc_sync_stage.sv ***
// Two flip-flop synchroniser for the external sync line.
`timescale 1ns/100ps
module awsc_sync_stage (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta;
  logic next_meta;
  logic next_sync;

  always_comb begin
    next_meta = async_in;
    next_sync = meta;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync;
    end
  end
endmodule

// *** awsc_top.sv ***
// Converter wake-up and multi-device sync control with a Wishbone slave.
// How it works
// - Writing core sleep bit in power control puts the core asleep.
// - Converter keeps running while the core sleeps.
// - Unmasked converter interrupt wakes the core; sleep bit clears.
// - Interrupt needs aux enable bit 0x20 and the global enable.
// - Reading the result clears the conversion ready request.
// - Converter stop bit 0x08 at f1 stops the converter clock.
// - Seeing sync high, wait for next completion, then set stop.
// - While stopped, watch sync; on its fall clear the stop bit.
// - Restart follows the sync fall within a few clock cycles.
`timescale 1ns/100ps
module awsc_top #(
  parameter int RESULT_W = 24
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [7:0] wb_dat_in,
  input wire logic wb_sel_in,
  output logic [7:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic conv_done_in,
  input wire logic [RESULT_W-1:0] conv_result_in,
  input wire logic sync_pin_in,
  output logic core_sleep_out,
  output logic conv_clk_en_out,
  output logic conv_irq_out
);
  logic sync_lvl;
  logic [7:0] power_control_reg;
  logic [7:0] aux_interrupt_enable_reg;
  logic [7:0] peripheral_power_down_reg;
  logic [7:0] aux_ctrl;
  logic conversion_ready_request;
  logic [RESULT_W-1:0] result;
  logic [7:0] rd_data;
  logic ack;
  awsc_pkg::awsc_sync_e state;
  logic [7:0] next_power_control_reg;
  logic [7:0] next_aux_interrupt_enable_reg;
  logic [7:0] next_peripheral_power_down_reg;
  logic [7:0] next_aux_ctrl;
  logic next_conversion_ready_request;
  logic [RESULT_W-1:0] next_result;
  logic [7:0] next_rd_data;
  logic next_ack;
  awsc_pkg::awsc_sync_e next_state;
  logic req;
  logic wr;
  logic rd;
  logic irq_active;
  logic [31:0] result_wide;
  logic stop_set;
  logic stop_clr;

  awsc_sync_stage u_sync (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .async_in(sync_pin_in),
    .sync_out(sync_lvl)
  );

  assign req = wb_cyc_in && wb_stb_in && !ack;
  assign wr = req && wb_we_in && wb_sel_in;
  assign rd = req && !wb_we_in;
  assign result_wide = 32'(result);
  // Converter event reaches the core only when both enables are set.
  assign irq_active = conversion_ready_request &&
    aux_interrupt_enable_reg[awsc_pkg::CONV_IRQ_POS] &&
    aux_ctrl[awsc_pkg::GLOBAL_EN_POS];

  // A completion counts only while the converter clock runs.
  function automatic logic done_taken(input logic done, input logic clk_en);
    return done && clk_en;
  endfunction

  // Status byte: sync level, ready request and sequencer state.
  function automatic logic [7:0] status_word(input logic sync,
      input logic ready, input logic [1:0] st);
    return {4'h0, sync, ready, st};
  endfunction

  // Bus response: one-cycle ack and registered read data.
  always_comb begin
    next_ack = req;
    next_rd_data = rd_data;
    if (rd) begin
      case (wb_adr_in)
        awsc_pkg::PWR_CTRL_OFF: next_rd_data = power_control_reg;
        awsc_pkg::AUX_IE_OFF: next_rd_data = aux_interrupt_enable_reg;
        awsc_pkg::PERIPH_PD_OFF: next_rd_data = peripheral_power_down_reg;
        awsc_pkg::AUX_CTRL_OFF: next_rd_data = aux_ctrl;
        awsc_pkg::STATUS_OFF: begin
          next_rd_data = status_word(sync_lvl, conversion_ready_request,
            state);
        end
        awsc_pkg::RESULT_OFF: next_rd_data = result_wide[7:0];
        default: next_rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data <= 8'h00;
      ack <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      ack <= next_ack;
    end
  end

  // Sync sequencer: asks the register group to set or clear the stop bit.
  always_comb begin
    next_state = state;
    stop_set = 1'b0;
    stop_clr = 1'b0;
    case (state)
      awsc_pkg::AWSC_IDLE: begin
        if (aux_ctrl[awsc_pkg::SYNC_AUTO_POS] && sync_lvl) begin
          next_state = awsc_pkg::AWSC_ARMED;
        end
      end
      awsc_pkg::AWSC_ARMED: begin
        if (done_taken(conv_done_in, conv_clk_en_out)) begin
          stop_set = 1'b1;
          next_state = awsc_pkg::AWSC_STOPPED;
        end else if (!aux_ctrl[awsc_pkg::SYNC_AUTO_POS]) begin
          next_state = awsc_pkg::AWSC_IDLE;
        end
      end
      awsc_pkg::AWSC_STOPPED: begin
        if (!sync_lvl) begin
          stop_clr = 1'b1;
          next_state = awsc_pkg::AWSC_IDLE;
        end
      end
      default: next_state = awsc_pkg::AWSC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= awsc_pkg::AWSC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Software registers, with the hardware updates applied last.
  always_comb begin
    next_power_control_reg = power_control_reg;
    next_aux_interrupt_enable_reg = aux_interrupt_enable_reg;
    next_peripheral_power_down_reg = peripheral_power_down_reg;
    next_aux_ctrl = aux_ctrl;
    next_conversion_ready_request = conversion_ready_request;
    next_result = result;
    if (wr) begin
      case (wb_adr_in)
        awsc_pkg::PWR_CTRL_OFF: begin
          next_power_control_reg = wb_dat_in;
        end
        awsc_pkg::AUX_IE_OFF: begin
          next_aux_interrupt_enable_reg = wb_dat_in;
        end
        awsc_pkg::PERIPH_PD_OFF: begin
          next_peripheral_power_down_reg = wb_dat_in;
        end
        awsc_pkg::AUX_CTRL_OFF: begin
          next_aux_ctrl = wb_dat_in & 8'h03;
        end
        default: begin
        end
      endcase
    end
    if (rd && wb_adr_in == awsc_pkg::RESULT_OFF) begin
      next_conversion_ready_request = 1'b0;
    end
    // A completion in the same cycle as the clearing read wins.
    if (done_taken(conv_done_in, conv_clk_en_out)) begin
      next_conversion_ready_request = 1'b1;
      next_result = conv_result_in;
    end
    // The wake-up ends sleep; the sleep write itself never blocks it.
    if (irq_active) begin
      next_power_control_reg[awsc_pkg::CORE_SLEEP_POS] = 1'b0;
    end
    // The sequencer wins over a software write in the same cycle.
    if (stop_set) begin
      next_peripheral_power_down_reg[awsc_pkg::CONV_STOP_POS] = 1'b1;
    end
    if (stop_clr) begin
      next_peripheral_power_down_reg[awsc_pkg::CONV_STOP_POS] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      power_control_reg <= awsc_pkg::PWR_CTRL_RST;
      aux_interrupt_enable_reg <= awsc_pkg::AUX_IE_RST;
      peripheral_power_down_reg <= awsc_pkg::PERIPH_PD_RST;
      aux_ctrl <= awsc_pkg::AUX_CTRL_RST;
      conversion_ready_request <= 1'b0;
      result <= '0;
    end else begin
      power_control_reg <= next_power_control_reg;
      aux_interrupt_enable_reg <= next_aux_interrupt_enable_reg;
      peripheral_power_down_reg <= next_peripheral_power_down_reg;
      aux_ctrl <= next_aux_ctrl;
      conversion_ready_request <= next_conversion_ready_request;
      result <= next_result;
    end
  end

  assign wb_ack_out = ack;
  assign wb_dat_out = rd_data;
  assign core_sleep_out = power_control_reg[awsc_pkg::CORE_SLEEP_POS];
  // Converter clock runs regardless of core sleep.
  assign conv_clk_en_out =
    !peripheral_power_down_reg[awsc_pkg::CONV_STOP_POS];
  assign conv_irq_out = irq_active;
endmodule

// *** awsc_top_asserts.sv ***
// Checker on the ports of the converter wake and sync block.
`timescale 1ns/100ps
module awsc_top_asserts (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [7:0] wb_dat_in,
  input wire logic wb_sel_in,
  input wire logic wb_ack_out,
  input wire logic conv_done_in,
  input wire logic sync_pin_in,
  input wire logic core_sleep_out,
  input wire logic conv_clk_en_out,
  input wire logic conv_irq_out
);
  logic acc, wr, stop_wr;
  assign acc = wb_cyc_in && wb_stb_in && wb_ack_out;
  assign wr = acc && wb_we_in && wb_sel_in;
  assign stop_wr = wb_dat_in[3];
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  a_sleep_set: assert property (
    wr && wb_adr_in == 8'h87 && wb_dat_in[1] && !conv_irq_out
    && !conv_done_in |=> core_sleep_out) else $error("sleep not set");
  a_irq_wakes: assert property (
    conv_irq_out |=> !core_sleep_out) else $error("core not woken");
  a_irq_cause: assert property (
    $rose(conv_irq_out) |-> $past(conv_done_in) || wr)
    else $error("irq without cause");
  a_read_clears: assert property (
    acc && !wb_we_in && wb_adr_in == 8'ha9 && !conv_done_in
    && !$past(conv_done_in) |=> !conv_irq_out) else $error("irq kept");
  a_stop_write: assert property (
    wr && wb_adr_in == 8'hf1 && !conv_done_in && !$past(conv_done_in)
    && !$past(conv_done_in, 2) && !$past(sync_pin_in, 2)
    && !$past(sync_pin_in, 3) && !$past(sync_pin_in, 4)
    |=> conv_clk_en_out != $past(stop_wr)) else $error("clk_en wrong");
  a_stop_cause: assert property (
    $fell(conv_clk_en_out) |-> $past(conv_done_in)
    || $past(conv_done_in, 2) || wr) else $error("early stop");
  a_sync_restart: assert property (
    $fell(sync_pin_in) && !conv_clk_en_out |-> ##[2:4] conv_clk_en_out)
    else $error("no restart");
  a_sync_lag: assert property (
    $fell(sync_pin_in) && !conv_clk_en_out |=> !conv_clk_en_out)
    else $error("restart too soon");
endmodule
bind awsc_top awsc_top_asserts i_awsc_top_asserts (.ref_clk_in, .rstn_in,
  .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_in, .wb_sel_in,
  .wb_ack_out,
  .conv_done_in, .sync_pin_in, .core_sleep_out, .conv_clk_en_out,
  .conv_irq_out);

// *** awsc_sync_master.sv ***
// Model of the external master that owns the shared sync line.
`timescale 1ns/100ps
module awsc_sync_master (
  input wire logic clk_in,
  output logic sync_out
);
  initial sync_out = 1'b0;
  // High asks all devices to prepare, low releases them together.
  task automatic drive(input logic lvl);
    @(posedge clk_in);
    sync_out <= lvl;
  endtask
endmodule

// *** awsc_top_tb.sv ***
// Testbench for the converter wake and sync block.
`timescale 1ns/100ps
module awsc_top_tb;
  logic ref_clk_in = 0, rstn_in = 0, wb_cyc_in = 0, wb_stb_in = 0;
  logic wb_we_in = 0, wb_sel_in = 1, conv_done_in = 0;
  logic [7:0] wb_adr_in = 0, wb_dat_in = 0, wb_dat_out, q;
  logic [23:0] conv_result_in = 0;
  logic wb_ack_out, sync_pin_in, core_sleep_out, conv_clk_en_out;
  logic conv_irq_out;
  logic sel_req = 1;
  int n_errors = 0, checked = 0, cycles = 0;
  awsc_top i_awsc_top (.ref_clk_in, .rstn_in, .wb_cyc_in, .wb_stb_in,
    .wb_we_in, .wb_adr_in, .wb_dat_in, .wb_sel_in, .wb_dat_out,
    .wb_ack_out, .conv_done_in, .conv_result_in, .sync_pin_in,
    .core_sleep_out, .conv_clk_en_out, .conv_irq_out);
  awsc_sync_master i_awsc_sync_master (.clk_in(ref_clk_in),
    .sync_out(sync_pin_in));
  initial forever #2.5 ref_clk_in = ~ref_clk_in;
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles > 3000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, d);
    @(posedge ref_clk_in);
    {wb_cyc_in, wb_stb_in, wb_we_in} <= {2'b11, w};
    {wb_adr_in, wb_dat_in} <= {a, d};
    wb_sel_in <= sel_req;
    do begin
      @(posedge ref_clk_in);
    end while (wb_ack_out !== 1'b1);
    q = wb_dat_out;
    {wb_cyc_in, wb_stb_in} <= 2'b00;
  endtask
  task automatic conv(input logic [23:0] r);
    @(posedge ref_clk_in);
    {conv_done_in, conv_result_in} <= {1'b1, r};
    @(posedge ref_clk_in);
    conv_done_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    chk("rst_clk_en", 1, conv_clk_en_out);
    wb(1, 8'ha6, 8'h20);
    wb(0, 8'ha6, 0);
    chk("aux_ie", 8'h20, q);
    wb(1, 8'ha7, 8'h01);
    wb(1, 8'h87, 8'h02);
    repeat (2) @(posedge ref_clk_in);
    chk("sleep", 1, core_sleep_out);
    chk("clk_en", 1, conv_clk_en_out);
    conv(24'h12345a);
    chk("irq", 1, conv_irq_out);
    chk("woken", 0, core_sleep_out);
    wb(0, 8'ha9, 0);
    chk("result", 8'h5a, q);
    @(posedge ref_clk_in);
    chk("irq_clr", 0, conv_irq_out);
    wb(1, 8'hf1, 8'h08);
    @(posedge ref_clk_in);
    chk("stopped", 0, conv_clk_en_out);
    wb(0, 8'hf1, 0);
    chk("pd_reg", 8'h08, q);
    sel_req = 1'b0;
    wb(1, 8'hf1, 8'h00);
    sel_req = 1'b1;
    wb(0, 8'hf1, 0);
    chk("sel_low", 8'h08, q);
    wb(1, 8'hf1, 0);
    @(posedge ref_clk_in);
    chk("running", 1, conv_clk_en_out);
    wb(0, 8'h10, 0);
    chk("unmapped", 0, q);
    wb(1, 8'ha7, 8'h03);
    i_awsc_sync_master.drive(1);
    repeat (6) @(posedge ref_clk_in);
    chk("armed", 1, conv_clk_en_out);
    wb(0, 8'ha8, 0);
    chk("status", 8'h09, q);
    conv(24'h000077);
    chk("sync_stop", 0, conv_clk_en_out);
    i_awsc_sync_master.drive(0);
    @(posedge ref_clk_in);
    chk("held", 0, conv_clk_en_out);
    repeat (4) @(posedge ref_clk_in);
    chk("restart", 1, conv_clk_en_out);
    wb(0, 8'ha9, 0);
    wb(1, 8'ha7, 0);
    conv(24'h000001);
    chk("masked", 0, conv_irq_out);
    tally_and_finish;
  end
endmodule
